/* File: prmc_top.sv */
// power reduction mode controller: mode register, wake qualification, stabilisation
// assumes wake sources and reset requests are asynchronous pins; register port on sys_clk_i
`timescale 1ns/10ps
module prmc_top
	import prmc_pkg::*;
#(
	parameter int RC_CYCLES  = PRMC_RC_CYCLES,
	parameter int XTAL_CLKS  = PRMC_XTAL_CLKS,
	parameter int EXT_CYCLES = PRMC_EXT_CYCLES
) (
	input  wire logic       sys_clk_i,
	input  wire logic       resetn_i,
	input  wire logic [7:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rdata_o,
	input  wire logic [6:0] wake_irq_i,
	input  wire logic [6:0] wake_irq_en_i,
	input  wire logic       global_irq_enable_i,
	input  wire logic       wake_reset_i,
	input  wire logic       wake_reset_en_i,
	input  wire logic [1:0] osc_select_i,
	input  wire logic       rtc_enable_i,
	input  wire logic       watchdog_clock_select_i,
	input  wire logic       comparator_enable_i,
	output logic            cpu_halt_o,
	output logic            osc_run_o,
	output logic            rc_osc_run_o,
	output logic            watchdog_run_o,
	output logic            comparator_run_o,
	output logic            rtc_run_o,
	output logic            brownout_run_o,
	output logic            brownout_irq_enable_o,
	output logic            irq_o
);
	typedef struct packed {
		prmc_state_t state;
		logic [7:0]  pctl;
		logic [7:0]  pctl2;
		logic [2:0]  irq_st;
		logic [2:0]  irq_msk;
		logic [7:0]  rdata;
		logic        halt;
		logic        osc;
		logic        rc;
		logic        wdt;
		logic        cmp;
		logic        rtc;
		logic        bod;
		logic        brownout_irq_enable;
		logic        irq;
	} prmc_st_t;
	prmc_st_t st_q;
	prmc_st_t st_d;

	prmc_sync_if #(.W(PRMC_NSRC + 1), .CW(PRMC_CNT_W)) sif ();

	prmc_sync #(
		.W  (PRMC_NSRC + 1),
		.CW (PRMC_CNT_W)
	) prmc_sync_i (
		.sys_clk_i (sys_clk_i),
		.resetn_i  (resetn_i),
		.s         (sif),
		.c         (sif)
	);

	logic [PRMC_NSRC-1:0] irq_s;
	logic                 rst_s;
	logic [PRMC_NSRC-1:0] src_allow;
	logic                 irq_wake;
	logic                 rst_wake;
	logic                 any_wake;
	logic [1:0]           mode;
	logic [PRMC_CNT_W-1:0] stab_load;
	logic                 pd_any;
	logic                 tpd;

	assign sif.raw = {wake_reset_i, wake_irq_i};
	assign irq_s   = sif.synced[PRMC_NSRC-1:0];
	assign rst_s   = sif.synced[PRMC_NSRC];
	assign mode    = st_q.pctl[PRMC_BIT_MODE_HI:PRMC_BIT_MODE_LO];
	assign pd_any  = (st_q.state == PRMC_ST_SLEEP);
	assign tpd     = (mode == PRMC_MODE_TPD);

	always_comb begin
		src_allow = '1;
		if (tpd)
			src_allow = PRMC_TPD_WAKE;
		// watchdog wakes only with its clock running
		if (!watchdog_clock_select_i)
			src_allow[PRMC_SRC_WDT] = 1'b0;
		// no brownout or comparator in tpd
		if (tpd || st_q.pctl2[PRMC_BIT_CMP_PD] && !comparator_enable_i)
			src_allow[PRMC_SRC_CMP] = 1'b0;
		// rtc gated by its power-down bit
		if (st_q.pctl2[PRMC_BIT_RTC_PD])
			src_allow[PRMC_SRC_RTC] = 1'b0;
		// brownout irq needs its enable bit
		if (!st_q.pctl[PRMC_BIT_BOI])
			src_allow[PRMC_SRC_BOD] = 1'b0;
	end

	assign irq_wake = global_irq_enable_i && |(irq_s & wake_irq_en_i & src_allow);
	assign rst_wake = rst_s && wake_reset_en_i;
	assign any_wake = irq_wake || rst_wake;

	always_comb begin
		case (osc_select_i)
			PRMC_OSC_XTAL: stab_load = PRMC_CNT_W'(XTAL_CLKS);
			PRMC_OSC_RC:   stab_load = PRMC_CNT_W'(RC_CYCLES);
			PRMC_OSC_EXT:  stab_load = PRMC_CNT_W'(EXT_CYCLES);
			default:       stab_load = PRMC_CNT_W'(XTAL_CLKS);
		endcase
	end

	assign sif.start = pd_any && any_wake;
	assign sif.load  = stab_load;

	always_comb begin
		logic [2:0] evt;
		logic [7:0] rd;
		evt  = '0;
		rd   = '0;
		st_d = st_q;

		if (wr_i) begin
			case (addr_i)
				PRMC_ADDR_PCTL: begin
					st_d.pctl = wdata_i & PRMC_PCTL_WMASK;
				end
				PRMC_ADDR_PCTL2: begin
					st_d.pctl2 = wdata_i & PRMC_PCTL2_WMASK;
				end
				PRMC_ADDR_IRQST: begin
					st_d.irq_st = st_q.irq_st & ~wdata_i[2:0];
				end
				PRMC_ADDR_IRQMSK: begin
					st_d.irq_msk = wdata_i[2:0];
				end
				default: begin
				end
			endcase
		end

		case (st_q.state)
			PRMC_ST_RUN: begin
				if (wr_i && addr_i == PRMC_ADDR_PCTL) begin
					if (wdata_i[1:0] == PRMC_MODE_IDLE) begin
						st_d.state = PRMC_ST_IDLE;
					end else if (wdata_i[PRMC_BIT_MODE_HI]) begin
						st_d.state = PRMC_ST_SLEEP;
						evt        = PRMC_EVT_PD;
					end
				end
			end
			PRMC_ST_IDLE: begin
				// any enabled irq or reset ends idle
				if ((global_irq_enable_i && |(irq_s & wake_irq_en_i)) || rst_wake) begin
					st_d.state = PRMC_ST_RUN;
					st_d.pctl[PRMC_BIT_MODE_HI:PRMC_BIT_MODE_LO] = PRMC_MODE_NORMAL;
					evt        = PRMC_EVT_IDLE;
				end
			end
			PRMC_ST_SLEEP: begin
				if (any_wake)
					st_d.state = PRMC_ST_STAB;
			end
			PRMC_ST_STAB: begin
				// hold until the oscillator is stable
				if (sif.done) begin
					st_d.state = PRMC_ST_RUN;
					st_d.pctl[PRMC_BIT_MODE_HI:PRMC_BIT_MODE_LO] = PRMC_MODE_NORMAL;
					evt        = PRMC_EVT_WAKE;
				end
			end
			default: st_d.state = PRMC_ST_RUN;
		endcase

		// set wins over a same-cycle clear
		st_d.irq_st = st_d.irq_st | evt;

		case (addr_i)
			PRMC_ADDR_PCTL:   rd = st_q.pctl;
			PRMC_ADDR_PCTL2:  rd = st_q.pctl2;
			PRMC_ADDR_IRQST:  rd = {5'h00, st_q.irq_st};
			PRMC_ADDR_IRQMSK: rd = {5'h00, st_q.irq_msk};
			PRMC_ADDR_STAT:   rd = {6'h00, st_q.state};
			default:          rd = 8'h00;
		endcase
		st_d.rdata = rd_i ? rd : 8'h00;

		st_d.halt = (st_d.state != PRMC_ST_RUN);
		st_d.osc  = (st_d.state != PRMC_ST_SLEEP);
		// rc kept only as sysclk with rtc on
		st_d.rc   = (st_d.state != PRMC_ST_SLEEP) ? (osc_select_i == PRMC_OSC_RC) :
		            (osc_select_i == PRMC_OSC_RC && rtc_enable_i && !st_q.pctl2[PRMC_BIT_RTC_PD]);
		st_d.wdt  = (st_d.state != PRMC_ST_SLEEP) || watchdog_clock_select_i;
		// comparators off if disabled and powered down, or asleep in tpd
		st_d.cmp  = !(st_q.pctl2[PRMC_BIT_CMP_PD] && !comparator_enable_i) &&
		            !(st_d.state == PRMC_ST_SLEEP && tpd);
		// rtc runs when enabled and its power-down bit is clear
		st_d.rtc  = rtc_enable_i && !st_q.pctl2[PRMC_BIT_RTC_PD];
		st_d.bod  = !(st_d.state == PRMC_ST_SLEEP && tpd);
		st_d.brownout_irq_enable  = st_d.bod && st_q.pctl[PRMC_BIT_BOI];
		st_d.irq  = |(st_d.irq_st & st_d.irq_msk);
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_q       <= '0;
			st_q.pctl  <= PRMC_PCTL_RST;
			st_q.state <= PRMC_ST_RUN;
			st_q.osc   <= 1'b1;
			st_q.wdt   <= 1'b1;
			st_q.cmp   <= 1'b1;
			st_q.bod   <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	assign rdata_o               = st_q.rdata;
	assign cpu_halt_o            = st_q.halt;
	assign osc_run_o             = st_q.osc;
	assign rc_osc_run_o          = st_q.rc;
	assign watchdog_run_o        = st_q.wdt;
	assign comparator_run_o      = st_q.cmp;
	assign rtc_run_o             = st_q.rtc;
	assign brownout_run_o        = st_q.bod;
	assign brownout_irq_enable_o = st_q.brownout_irq_enable;
	assign irq_o                 = st_q.irq;
endmodule

/* File: prmc_pkg.sv */
// constants and types for the power reduction mode controller
// assumes a single 25 MHz system clock and an 8-bit register port
package prmc_pkg;
	localparam logic [7:0] PRMC_ADDR_PCTL   = 8'h87;
	localparam logic [7:0] PRMC_ADDR_PCTL2  = 8'hB5;
	localparam logic [7:0] PRMC_ADDR_IRQST  = 8'hC0;
	localparam logic [7:0] PRMC_ADDR_IRQMSK = 8'hC1;
	localparam logic [7:0] PRMC_ADDR_STAT   = 8'hC2;
	localparam logic [7:0] PRMC_PCTL_RST    = 8'h00;
	localparam logic [7:0] PRMC_PCTL_WMASK  = 8'hDF;
	localparam logic [7:0] PRMC_PCTL2_WMASK = 8'hBA;
	localparam int PRMC_BIT_MODE_LO   = 0;
	localparam int PRMC_BIT_MODE_HI   = 1;
	localparam int PRMC_BIT_BOI       = 4;
	localparam int PRMC_BIT_CMP_PD    = 5;
	localparam int PRMC_BIT_RTC_PD    = 7;
	localparam logic [1:0] PRMC_MODE_NORMAL = 2'h0;
	localparam logic [1:0] PRMC_MODE_IDLE   = 2'h1;
	localparam logic [1:0] PRMC_MODE_PD     = 2'h2;
	localparam logic [1:0] PRMC_MODE_TPD    = 2'h3;
	localparam logic [1:0] PRMC_OSC_XTAL = 2'h0;
	localparam logic [1:0] PRMC_OSC_RC   = 2'h1;
	localparam logic [1:0] PRMC_OSC_EXT  = 2'h2;
	localparam int PRMC_CLK_HZ      = 25000000;
	localparam int PRMC_XTAL_CLKS   = 1024;
	localparam int PRMC_RC_MS       = 200;
	localparam int PRMC_EXT_CYCLES  = 32;
	localparam int PRMC_RC_CYCLES   = (PRMC_CLK_HZ / 1000) * PRMC_RC_MS;
	localparam int PRMC_CNT_W       = 24;
	// wake sources: 0 ext0,1 ext1,2 bod,3 kbd,4 rtc,5 wdt,6 cmp
	localparam int PRMC_NSRC = 7;
	localparam int PRMC_SRC_BOD = 2;
	localparam int PRMC_SRC_RTC = 4;
	localparam int PRMC_SRC_WDT = 5;
	localparam int PRMC_SRC_CMP = 6;
	localparam logic [6:0] PRMC_TPD_WAKE = 7'h3B;
	localparam logic [2:0] PRMC_EVT_PD   = 3'h1;
	localparam logic [2:0] PRMC_EVT_WAKE = 3'h2;
	localparam logic [2:0] PRMC_EVT_IDLE = 3'h4;
	typedef enum logic [1:0] {
		PRMC_ST_RUN,
		PRMC_ST_IDLE,
		PRMC_ST_SLEEP,
		PRMC_ST_STAB
	} prmc_state_t;
endpackage

/* File: prmc_sync_if.sv */
// bundle between the top and its synchroniser and stabilisation counter
// assumes all members except raw live on sys_clk_i; raw carries the asynchronous wake and reset pins
`timescale 1ns/10ps
interface prmc_sync_if #(parameter int W = 7, parameter int CW = 24);
	logic [W-1:0]  raw;
	logic [W-1:0]  synced;
	logic          start;
	logic [CW-1:0] load;
	logic          done;
	modport sync_side (input raw, output synced);
	modport cnt_side  (input start, input load, output done);
	modport top_side  (output raw, input synced, output start, output load, input done);
endinterface

/* File: prmc_sync.sv */
// two-flop synchroniser bank plus the oscillator stabilisation counter
// assumes asynchronous inputs and a running sys_clk_i
`timescale 1ns/10ps
module prmc_sync #(
	parameter int W  = 7,
	parameter int CW = 24
) (
	input  wire logic            sys_clk_i,
	input  wire logic            resetn_i,
	prmc_sync_if.sync_side       s,
	prmc_sync_if.cnt_side        c
);
	typedef struct packed {
		logic [W-1:0]  meta;
		logic [W-1:0]  sync;
		logic [CW-1:0] cnt;
		logic          busy;
	} prmc_sync_st_t;
	prmc_sync_st_t st_q;
	prmc_sync_st_t st_d;

	always_comb begin
		st_d      = st_q;
		st_d.meta = s.raw;
		st_d.sync = st_q.meta;
		if (c.start) begin
			st_d.cnt  = c.load;
			st_d.busy = 1'b1;
		end else if (st_q.busy) begin
			if (st_q.cnt <= CW'(1))
				st_d.busy = 1'b0;
			st_d.cnt = st_q.cnt - CW'(1);
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign s.synced = st_q.sync;
	assign c.done   = st_q.busy && (st_q.cnt <= CW'(1)) && !c.start;
endmodule

/* File: prmc_monitor.sv */
// port checker for the power reduction mode controller
// assumes binding to prmc_top, one clock domain on sys_clk_i
`timescale 1ns/10ps
module prmc_monitor
	import prmc_pkg::*;
#(
	parameter int RC_CYCLES  = PRMC_RC_CYCLES,
	parameter int XTAL_CLKS  = PRMC_XTAL_CLKS,
	parameter int EXT_CYCLES = PRMC_EXT_CYCLES
) (
	input wire logic       sys_clk_i,
	input wire logic       resetn_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic       wr_i,
	input wire logic       rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic [1:0] osc_select_i,
	input wire logic       rtc_enable_i,
	input wire logic       watchdog_clock_select_i,
	input wire logic       comparator_enable_i,
	input wire logic       cpu_halt_o,
	input wire logic       osc_run_o,
	input wire logic       rc_osc_run_o,
	input wire logic       watchdog_run_o,
	input wire logic       comparator_run_o,
	input wire logic       rtc_run_o,
	input wire logic       brownout_run_o,
	input wire logic       brownout_irq_enable_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);
	logic mode_wr;
	// writes while halted only store bits, so only running writes are judged
	assign mode_wr = wr_i && addr_i == PRMC_ADDR_PCTL && !cpu_halt_o;
	chk_pd_osc_stop: assert property (mode_wr && wdata_i[1] |-> ##[1:2] !osc_run_o && cpu_halt_o)
		else $error("oscillator kept running after power-down write");
	chk_idle_halt: assert property (mode_wr && wdata_i[1:0] == PRMC_MODE_IDLE |-> ##[1:2] cpu_halt_o && osc_run_o)
		else $error("idle write did not halt the core");
	chk_tpd_parts_off: assert property (!brownout_run_o |-> !comparator_run_o && !osc_run_o)
		else $error("brownout off outside total power-down");
	chk_bod_irq_live: assert property (brownout_irq_enable_o |-> brownout_run_o)
		else $error("brownout irq enabled with detector off");
	chk_rc_keep: assert property (rc_osc_run_o && !osc_run_o |-> $past(osc_select_i) == PRMC_OSC_RC && $past(rtc_enable_i))
		else $error("rc oscillator running asleep without cause");
	chk_wdt_gate: assert property (!watchdog_run_o |-> !osc_run_o && !$past(watchdog_clock_select_i))
		else $error("watchdog stopped wrongly");
	chk_cmp_gate: assert property (!comparator_run_o |-> !$past(comparator_enable_i) || !brownout_run_o)
		else $error("enabled comparator stopped");
	chk_rtc_gate: assert property (rtc_run_o |-> $past(rtc_enable_i))
		else $error("rtc running while disabled");
	chk_stab_hold: assert property ($rose(osc_run_o) |-> cpu_halt_o [*8])
		else $error("core resumed before oscillator settled");
	chk_rd_quiet: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data outside read answer cycle");
	cover property ($fell(osc_run_o));
	cover property (!brownout_run_o);
	cover property ($fell(cpu_halt_o));
endmodule
bind prmc_top prmc_monitor #(.RC_CYCLES(RC_CYCLES), .XTAL_CLKS(XTAL_CLKS), .EXT_CYCLES(EXT_CYCLES)) prmc_monitor_i (.*);

/* File: prmc_wake_model.sv */
// wake source model: interrupt levels raised by the bench
// assumes one-cycle pulses on fire_i and the controller's halt output
`timescale 1ns/10ps
module prmc_wake_model (
	input  wire logic       sys_clk_i,
	input  wire logic       resetn_i,
	input  wire logic [6:0] fire_i,
	input  wire logic       cpu_halt_i,
	output logic      [6:0] wake_irq_o
);
	// level triggered sources
	// held until the core runs again, so a sleeping synchroniser cannot miss it
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wake_irq_o <= 7'h00;
		end else begin
			wake_irq_o <= fire_i | (wake_irq_o & {7{cpu_halt_i}});
		end
	end
endmodule

/* File: test_power_reduction_mode_control.sv */
// self-checking bench for the power reduction mode controller
// assumes prmc_top, its bound checker and the wake source model
`timescale 1ns/10ps
module test_power_reduction_mode_control;
	import prmc_pkg::*;
	logic       sys_clk_i, resetn_i, wr_i, rd_i, global_irq_enable_i, wake_reset_i, wake_reset_en_i;
	logic       rtc_enable_i, watchdog_clock_select_i, comparator_enable_i, irq_o;
	logic       cpu_halt_o, osc_run_o, rc_osc_run_o, watchdog_run_o, comparator_run_o, rtc_run_o;
	logic       brownout_run_o, brownout_irq_enable_o;
	logic [7:0] addr_i, wdata_i, rdata_o;
	logic [6:0] wake_irq_i, wake_irq_en_i, fire;
	logic [1:0] osc_select_i;
	int         num_errors, cmp_count, n;
	int         cyc = 0;
	int         loads [3] = '{PRMC_XTAL_CLKS, 50, PRMC_EXT_CYCLES};
	prmc_top #(.RC_CYCLES(50)) prmc_top_i (.*);
	prmc_wake_model prmc_wake_model_i (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .fire_i(fire),
		.cpu_halt_i(cpu_halt_o), .wake_irq_o(wake_irq_i));
	initial begin
		sys_clk_i = 1'b0;
		forever #20 sys_clk_i = ~sys_clk_i;
	end
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// the longest path is three crystal settles plus register traffic
	always @(posedge sys_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			tally_and_finish();
		end
	end
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic waitc(input int k);
		repeat (k) @(posedge sys_clk_i);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] exp);
		@(posedge sys_clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
		#1 chk(nm, rdata_o, exp);
	endtask
	task automatic pulse(input logic [6:0] m);
		@(posedge sys_clk_i);
		fire <= m;
		@(posedge sys_clk_i);
		fire <= 7'h00;
	endtask
	// cycles the core stays halted once the oscillator is back
	task automatic wake_len(output int len);
		int t;
		t = 0;
		len = 0;
		while (!osc_run_o && t < 200) begin
			waitc(1);
			t++;
		end
		while (cpu_halt_o && len < 2000) begin
			waitc(1);
			len++;
		end
	endtask
	initial begin
		{resetn_i, wr_i, rd_i, global_irq_enable_i, wake_reset_i, wake_reset_en_i, watchdog_clock_select_i} = '0;
		{rtc_enable_i, comparator_enable_i} = 2'h3;
		{addr_i, wdata_i} = 16'h0000;
		{wake_irq_en_i, fire} = 14'h0000;
		osc_select_i = PRMC_OSC_XTAL;
		num_errors = 0;
		cmp_count = 0;
		repeat (12) @(posedge sys_clk_i);
		resetn_i <= 1'b1;
		rdc("pctl reset", PRMC_ADDR_PCTL, PRMC_PCTL_RST);
		chk("halt after reset", cpu_halt_o, 0);
		wr(PRMC_ADDR_PCTL, 8'hFC);
		rdc("pctl bits", PRMC_ADDR_PCTL, 8'hDC);
		chk("boi out", brownout_irq_enable_o, 1);
		wr(PRMC_ADDR_PCTL2, 8'hFF);
		rdc("pctl2 bits", PRMC_ADDR_PCTL2, 8'hBA);
		chk("rtc gated", rtc_run_o, 0);
		chk("cmp still enabled", comparator_run_o, 1);
		@(posedge sys_clk_i);
		comparator_enable_i <= 1'b0;
		waitc(2);
		chk("cmp powered down", comparator_run_o, 0);
		wr(PRMC_ADDR_PCTL2, 8'h00);
		rdc("unmapped", 8'h10, 8'h00);
		chk("rtc back", rtc_run_o, 1);
		wr(PRMC_ADDR_PCTL, 8'h00);
		wr(PRMC_ADDR_IRQMSK, 8'h07);
		global_irq_enable_i <= 1'b1;
		wake_irq_en_i <= 7'h01;
		wr(PRMC_ADDR_PCTL, 8'h01);
		waitc(2);
		chk("idle halt", cpu_halt_o, 1);
		chk("idle osc", osc_run_o, 1);
		rdc("idle state", PRMC_ADDR_STAT, 8'h01);
		pulse(7'h01);
		waitc(8);
		chk("idle end", cpu_halt_o, 0);
		rdc("idle mode back", PRMC_ADDR_PCTL, 8'h00);
		rdc("idle flag", PRMC_ADDR_IRQST, 8'h04);
		chk("irq up", irq_o, 1);
		wr(PRMC_ADDR_IRQMSK, 8'h00);
		waitc(2);
		chk("irq masked", irq_o, 0);
		wr(PRMC_ADDR_IRQMSK, 8'h07);
		wr(PRMC_ADDR_IRQST, 8'h04);
		waitc(2);
		chk("irq cleared", irq_o, 0);
		for (int i = 0; i < 3; i++) begin
			@(posedge sys_clk_i);
			osc_select_i <= 2'(i);
			watchdog_clock_select_i <= (i == 2);
			wake_irq_en_i <= 7'h00;
			wr(PRMC_ADDR_PCTL, 8'h02);
			waitc(2);
			chk("pd osc", osc_run_o, 0);
			chk("pd bod", brownout_run_o, 1);
			chk("pd cmp", comparator_run_o, 1);
			chk("pd rc", rc_osc_run_o, i == 1);
			chk("pd wdt", watchdog_run_o, i == 2);
			chk("pd rtc", rtc_run_o, 1);
			if (i == 0) begin
				@(posedge sys_clk_i);
				wake_reset_i <= 1'b1;
				waitc(10);
				chk("reset source off", osc_run_o, 0);
				@(posedge sys_clk_i);
				wake_reset_en_i <= 1'b1;
			end else begin
				@(posedge sys_clk_i);
				global_irq_enable_i <= 1'b0;
				wake_irq_en_i <= 7'h01;
				pulse(7'h01);
				waitc(10);
				chk("global enable off", osc_run_o, 0);
				@(posedge sys_clk_i);
				global_irq_enable_i <= 1'b1;
			end
			wake_len(n);
			chk("settle length", n, loads[i]);
			@(posedge sys_clk_i);
			wake_reset_i <= 1'b0;
			wake_reset_en_i <= 1'b0;
			rdc("pd mode back", PRMC_ADDR_PCTL, 8'h00);
		end
		@(posedge sys_clk_i);
		osc_select_i <= PRMC_OSC_XTAL;
		watchdog_clock_select_i <= 1'b0;
		wake_irq_en_i <= 7'h7F;
		// flags left from the loop would hide the total power-down ones
		wr(PRMC_ADDR_IRQST, 8'h07);
		wr(PRMC_ADDR_PCTL, 8'h13);
		waitc(2);
		chk("tpd bod", brownout_run_o, 0);
		chk("tpd cmp", comparator_run_o, 0);
		chk("tpd boi", brownout_irq_enable_o, 0);
		pulse(7'h44);
		waitc(10);
		chk("tpd bod cmp wake", osc_run_o, 0);
		pulse(7'h08);
		wake_len(n);
		chk("tpd kbd wake", n, 1024);
		rdc("tpd mode back", PRMC_ADDR_PCTL, 8'h10);
		rdc("pd flags", PRMC_ADDR_IRQST, 8'h03);
		@(posedge sys_clk_i);
		// unused source code settles as a crystal
		osc_select_i <= 2'h3;
		wr(PRMC_ADDR_PCTL, 8'h12);
		waitc(2);
		pulse(7'h04);
		wake_len(n);
		chk("brownout wake", n, PRMC_XTAL_CLKS);
		tally_and_finish();
	end
endmodule
